//--- lhrt_core.sv
// LIN header generator, role control and diagnostic gap timing.
// Assumes lin_rx is asynchronous, diag strobes come from same-clock logic.
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.

// Operation
// - Programmable extra delimiter after break, default 0
// - Built-in delimiter lasts break_len/9 bit times
// - Extra delimiter maximum follows break length table
// - Break length 10 to 36, reset 13
// - Below 9600 baud break limit is 14
// - Break length used only in master role
// - Slave waits request-to-response time, default 50 ms
// - Request-to-response write in master is rejected
// - Slave keeps gap between diagnostic response frames
// - Master keeps gap between diagnostic request frames
// - Role bit, reset slave, change only stopped
// - Master sends headers, one node answers each
// - Slave answers only matching remote headers
// - Schedule request forces master role unless running as slave (then refused)
// - Role decides who sends headers and who answers them
module lhrt_core #(
  parameter int MS_CYCLES = lhrt_pkg::MS_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire lhrt_pkg::lhrt_av_req_t av_req,
  output lhrt_pkg::lhrt_av_rsp_t av_rsp,
  input wire logic lin_rx,
  output logic lin_tx,
  input wire logic diag_req_rx_done,
  input wire logic diag_frame_tx_done,
  output logic resp_go,
  output logic irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    lhrt_pkg::lhrt_tx_t tx_state;
    logic [23:0] tcnt;
    logic [3:0] tbit;
    logic tbyte;
    logic [9:0] tsh;
    logic lin_tx;
    lhrt_pkg::lhrt_rx_t rx_state;
    logic rx_s1;
    logic rx_s2;
    logic [23:0] rcnt;
    logic [3:0] rbit;
    logic rbyte;
    logic [7:0] rsh;
    logic rsync_ok;
    logic run;
    logic master;
    logic sched_act;
    logic hdr_pend;
    logic [5:0] hdr_id;
    logic hdr_diag;
    logic [5:0] brk;
    logic [3:0] dlm;
    logic [15:0] p2;
    logic [15:0] stg;
    logic [5:0] resp_id;
    logic [15:0] div;
    logic [2:0] stat;
    logic [2:0] ien;
    logic irq;
    logic [15:0] mscnt;
    logic [16:0] p2_left;
    logic [16:0] st_left;
    logic resp_go;
    logic waitreq;
    logic [31:0] rdata;
  } lhrt_st_t;

  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

  lhrt_st_t s_r;
  lhrt_st_t s_nxt;
  logic wr;
  logic rd;
  logic [5:0] ba;
  logic [31:0] wd;
  logic [2:0] set_v;
  logic [2:0] clr_v;
  logic tick;
  logic gap_ok;
  logic [23:0] dv;
  logic [5:0] nb;
  logic [3:0] nd;
  logic [7:0] rbyte_v;

  assign av_rsp.readdata = s_r.rdata;
  assign av_rsp.waitrequest = s_r.waitreq;
  assign lin_tx = s_r.lin_tx;
  assign resp_go = s_r.resp_go;
  assign irq = s_r.irq;

  always_comb begin
    s_nxt = s_r;
    wr = av_req.write && !s_r.waitreq;
    rd = av_req.read && s_r.waitreq;
    ba = {av_req.address, 2'b00};
    wd = av_req.writedata;
    set_v = 3'h0;
    clr_v = 3'h0;
    dv = 24'(s_r.div);
    nb = wd[5:0];
    nd = wd[3:0];
    rbyte_v = {s_r.rx_s2, s_r.rsh[7:1]};
    s_nxt.resp_go = 1'b0;
    s_nxt.rx_s1 = lin_rx;
    s_nxt.rx_s2 = s_r.rx_s1;

    // ----------------------------------------
    // Millisecond base and gap timers
    // ----------------------------------------
    tick = (s_r.mscnt == MS_LAST);
    s_nxt.mscnt = tick ? 16'h0 : s_r.mscnt + 16'h1;
    // One extra ms is loaded so a partial first tick never shortens a gap
    if (tick && s_r.p2_left != 17'h0) begin
      s_nxt.p2_left = s_r.p2_left - 17'h1;
    end
    if (tick && s_r.st_left != 17'h0) begin
      s_nxt.st_left = s_r.st_left - 17'h1;
    end
    if (diag_req_rx_done) begin
      s_nxt.p2_left = (s_r.p2 == 16'h0) ? 17'h0 : {1'b0, s_r.p2} + 17'h1;
    end
    if (diag_frame_tx_done) begin
      s_nxt.st_left = (s_r.stg == 16'h0) ? 17'h0 : {1'b0, s_r.stg} + 17'h1;
    end
    gap_ok = (s_r.st_left == 17'h0);

    // ----------------------------------------
    // Header transmitter
    // ----------------------------------------
    case (s_r.tx_state)
      lhrt_pkg::T_IDLE: begin
        s_nxt.lin_tx = 1'b1;
        // diagnostic request header waits for gap
        if (s_r.run && s_r.master && s_r.hdr_pend && (!s_r.hdr_diag || gap_ok)) begin
          s_nxt.tcnt = 24'(s_r.brk) * dv - 24'h1;
          s_nxt.lin_tx = 1'b0;
          s_nxt.hdr_pend = 1'b0;
          s_nxt.tx_state = lhrt_pkg::T_BRK;
        end
      end
      lhrt_pkg::T_BRK: begin
        if (s_r.tcnt == 24'h0) begin
          s_nxt.lin_tx = 1'b1;
          s_nxt.tcnt = (24'(s_r.brk) * dv) / 24'(lhrt_pkg::BUILTIN_DIV)
                       + 24'(s_r.dlm) * dv - 24'h1;
          s_nxt.tx_state = lhrt_pkg::T_DLM;
        end else begin
          s_nxt.tcnt = s_r.tcnt - 24'h1;
        end
      end
      lhrt_pkg::T_DLM: begin
        if (s_r.tcnt == 24'h0) begin
          s_nxt.tsh = {1'b1, lhrt_pkg::SYNC_BYTE, 1'b0};
          s_nxt.lin_tx = 1'b0;
          s_nxt.tcnt = dv - 24'h1;
          s_nxt.tbit = 4'h0;
          s_nxt.tbyte = 1'b0;
          s_nxt.tx_state = lhrt_pkg::T_BYTE;
        end else begin
          s_nxt.tcnt = s_r.tcnt - 24'h1;
        end
      end
      lhrt_pkg::T_BYTE: begin
        if (s_r.tcnt != 24'h0) begin
          s_nxt.tcnt = s_r.tcnt - 24'h1;
        end else if (s_r.tbit != lhrt_pkg::LAST_BIT) begin
          s_nxt.tsh = {1'b1, s_r.tsh[9:1]};
          s_nxt.lin_tx = s_r.tsh[1];
          s_nxt.tbit = s_r.tbit + 4'h1;
          s_nxt.tcnt = dv - 24'h1;
        end else if (!s_r.tbyte) begin
          s_nxt.tsh = {1'b1, lhrt_pkg::pid(s_r.hdr_id), 1'b0};
          s_nxt.lin_tx = 1'b0;
          s_nxt.tbit = 4'h0;
          s_nxt.tbyte = 1'b1;
          s_nxt.tcnt = dv - 24'h1;
        end else begin
          set_v[lhrt_pkg::SB_HDR] = 1'b1;
          s_nxt.tx_state = lhrt_pkg::T_IDLE;
        end
      end
      default: begin
        s_nxt.lin_tx = 1'b1;
        s_nxt.tx_state = lhrt_pkg::T_IDLE;
      end
    endcase

    // ----------------------------------------
    // Header receiver, slave role
    // ----------------------------------------
    case (s_r.rx_state)
      lhrt_pkg::R_IDLE: begin
        if (s_r.run && !s_r.master && !s_r.rx_s2) begin
          s_nxt.rcnt = 24'h0;
          s_nxt.rx_state = lhrt_pkg::R_BRK;
        end
      end
      lhrt_pkg::R_BRK: begin
        if (!s_r.rx_s2) begin
          if (s_r.rcnt != 24'hff_ffff) begin
            s_nxt.rcnt = s_r.rcnt + 24'h1;
          end
        end else if (s_r.rcnt >= 24'(lhrt_pkg::SLV_BRK_MIN) * dv) begin
          s_nxt.rbyte = 1'b0;
          s_nxt.rx_state = lhrt_pkg::R_WAIT;
        end else begin
          s_nxt.rx_state = lhrt_pkg::R_IDLE;
        end
      end
      lhrt_pkg::R_WAIT: begin
        if (!s_r.rx_s2) begin
          // Sample mid-bit: one and a half bits after the start edge
          s_nxt.rcnt = dv + (dv >> 1) - 24'h1;
          s_nxt.rbit = 4'h0;
          s_nxt.rx_state = lhrt_pkg::R_BYTE;
        end
      end
      lhrt_pkg::R_BYTE: begin
        if (s_r.rcnt != 24'h0) begin
          s_nxt.rcnt = s_r.rcnt - 24'h1;
        end else begin
          s_nxt.rsh = rbyte_v;
          s_nxt.rbit = s_r.rbit + 4'h1;
          s_nxt.rcnt = dv - 24'h1;
          if (s_r.rbit == lhrt_pkg::RX_LAST) begin
            s_nxt.rx_state = lhrt_pkg::R_STOP;
          end
        end
      end
      lhrt_pkg::R_STOP: begin
        if (s_r.rcnt != 24'h0) begin
          s_nxt.rcnt = s_r.rcnt - 24'h1;
        end else if (!s_r.rbyte) begin
          s_nxt.rsync_ok = (s_r.rsh == lhrt_pkg::SYNC_BYTE) && s_r.rx_s2;
          s_nxt.rbyte = 1'b1;
          s_nxt.rx_state = lhrt_pkg::R_WAIT;
        end else begin
          // answer only own identifier
          // A role switch during reception must not release a response
          if (s_r.rsync_ok && s_r.rx_s2 && !s_r.master && s_r.rsh == lhrt_pkg::pid(s_r.resp_id)) begin
            set_v[lhrt_pkg::SB_MATCH] = 1'b1;
            // response released only if both gaps have already expired
            s_nxt.resp_go = (s_r.p2_left == 17'h0) && gap_ok;
          end
          s_nxt.rx_state = lhrt_pkg::R_IDLE;
        end
      end
      default: begin
        s_nxt.rx_state = lhrt_pkg::R_IDLE;
      end
    endcase

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    if (wr) begin
      case (ba)
        lhrt_pkg::OFS_CTRL: begin
          s_nxt.run = wd[0];
          if (!s_r.run && s_r.tx_state == lhrt_pkg::T_IDLE) begin
            s_nxt.master = wd[1];
          end else if (wd[1] != s_r.master) begin
            set_v[lhrt_pkg::SB_ERR] = 1'b1;
          end
          if (!wd[0]) begin
            s_nxt.sched_act = 1'b0;
            s_nxt.hdr_pend = 1'b0;
          end
        end
        lhrt_pkg::OFS_BRK: begin
          // low rates shrink the upper limit
          // Upper bits are checked so a large value is not aliased into range
          if (wd[31:6] == 26'h0 && nb >= lhrt_pkg::BRK_MIN && nb <= lhrt_pkg::brk_lim(s_r.div)
              && s_r.dlm <= lhrt_pkg::dlm_max(nb)) begin
            s_nxt.brk = nb;
          end else begin
            set_v[lhrt_pkg::SB_ERR] = 1'b1;
          end
        end
        lhrt_pkg::OFS_DLM: begin
          if (wd[31:4] == 28'h0 && nd <= lhrt_pkg::dlm_max(s_r.brk)) begin
            s_nxt.dlm = nd;
          end else begin
            set_v[lhrt_pkg::SB_ERR] = 1'b1;
          end
        end
        lhrt_pkg::OFS_P2: begin
          if (s_r.master) begin
            set_v[lhrt_pkg::SB_ERR] = 1'b1;
          end else begin
            s_nxt.p2 = wd[15:0];
          end
        end
        lhrt_pkg::OFS_ST: s_nxt.stg = wd[15:0];
        lhrt_pkg::OFS_SCHED: begin
          if (s_r.run && !s_r.master) begin
            set_v[lhrt_pkg::SB_ERR] = 1'b1;
          end else begin
            s_nxt.master = 1'b1;
            s_nxt.run = 1'b1;
            s_nxt.sched_act = 1'b1;
            s_nxt.hdr_pend = 1'b1;
            s_nxt.hdr_id = wd[5:0];
            s_nxt.hdr_diag = wd[8];
          end
        end
        lhrt_pkg::OFS_RESP: s_nxt.resp_id = wd[5:0];
        lhrt_pkg::OFS_DIV: begin
          if (wd[15:0] == 16'h0) begin
            set_v[lhrt_pkg::SB_ERR] = 1'b1;
          end else begin
            s_nxt.div = wd[15:0];
          end
        end
        lhrt_pkg::OFS_CLR: clr_v = wd[2:0];
        lhrt_pkg::OFS_IEN: s_nxt.ien = wd[2:0];
        default: begin
        end
      endcase
    end

    // ----------------------------------------
    // Status, interrupt and bus answer
    // ----------------------------------------
    // A set in the clearing cycle survives
    s_nxt.stat = (s_r.stat & ~clr_v) | set_v;
    s_nxt.irq = |(s_nxt.stat & s_nxt.ien);
    s_nxt.waitreq = !((av_req.read || av_req.write) && s_r.waitreq);
    if (rd) begin
      case (ba)
        lhrt_pkg::OFS_CTRL: s_nxt.rdata = {29'h0, s_r.sched_act, s_r.master, s_r.run};
        lhrt_pkg::OFS_BRK: s_nxt.rdata = {26'h0, s_r.brk};
        lhrt_pkg::OFS_DLM: s_nxt.rdata = {28'h0, s_r.dlm};
        lhrt_pkg::OFS_P2: s_nxt.rdata = {16'h0, s_r.p2};
        lhrt_pkg::OFS_ST: s_nxt.rdata = {16'h0, s_r.stg};
        lhrt_pkg::OFS_SCHED: s_nxt.rdata = {23'h0, s_r.hdr_diag, 2'b00, s_r.hdr_id};
        lhrt_pkg::OFS_RESP: s_nxt.rdata = {26'h0, s_r.resp_id};
        lhrt_pkg::OFS_DIV: s_nxt.rdata = {16'h0, s_r.div};
        lhrt_pkg::OFS_STAT: s_nxt.rdata = {29'h0, s_r.stat};
        lhrt_pkg::OFS_IEN: s_nxt.rdata = {29'h0, s_r.ien};
        lhrt_pkg::OFS_STATE: s_nxt.rdata = {15'h0, s_r.hdr_pend, 3'h0, s_r.rx_state, 4'h0, s_r.tx_state};
        default: s_nxt.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.tx_state <= lhrt_pkg::T_IDLE;
      s_r.rx_state <= lhrt_pkg::R_IDLE;
      s_r.lin_tx <= 1'b1;
      s_r.rx_s1 <= 1'b1;
      s_r.rx_s2 <= 1'b1;
      s_r.tsh <= 10'h3ff;
      s_r.brk <= lhrt_pkg::BRK_RST;
      s_r.dlm <= lhrt_pkg::DLM_RST;
      s_r.p2 <= lhrt_pkg::P2_RST;
      s_r.stg <= lhrt_pkg::ST_RST;
      s_r.div <= lhrt_pkg::DIV_RST;
      s_r.waitreq <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  brk_range_a : assert property (
    @(posedge clk) disable iff (reset)
    s_r.brk >= lhrt_pkg::BRK_MIN && s_r.brk <= lhrt_pkg::BRK_MAX)
    else $error("break length out of range");

  dlm_limit_a : assert property (
    @(posedge clk) disable iff (reset)
    s_r.dlm <= lhrt_pkg::dlm_max(s_r.brk))
    else $error("extra delimiter above maximum");

  dlm_len_a : assert property (
    @(posedge clk) disable iff (reset)
    s_r.tx_state == lhrt_pkg::T_BRK && s_r.tcnt == 24'h0 |=>
    s_r.tcnt == (24'($past(s_r.brk)) * 24'($past(s_r.div))) / 24'(lhrt_pkg::BUILTIN_DIV)
                + 24'($past(s_r.dlm)) * 24'($past(s_r.div)) - 24'h1 && s_r.lin_tx)
    else $error("delimiter length wrong");

  role_hold_a : assert property (
    @(posedge clk) disable iff (reset)
    $past(s_r.run) |-> $stable(s_r.master))
    else $error("role changed while running");

  sched_mst_a : assert property (
    @(posedge clk) disable iff (reset)
    wr && ba == lhrt_pkg::OFS_SCHED && !s_r.run |=> s_r.master && s_r.hdr_pend)
    else $error("schedule did not force master");

  p2_reject_a : assert property (
    @(posedge clk) disable iff (reset)
    wr && ba == lhrt_pkg::OFS_P2 && s_r.master |=>
    $stable(s_r.p2) && s_r.stat[lhrt_pkg::SB_ERR])
    else $error("master wrote request-to-response time");

  slave_quiet_a : assert property (
    @(posedge clk) disable iff (reset)
    s_r.tx_state != lhrt_pkg::T_IDLE |-> s_r.master)
    else $error("header sent in slave role");

  req_gap_a : assert property (
    @(posedge clk) disable iff (reset)
    s_r.tx_state == lhrt_pkg::T_IDLE && s_nxt.tx_state == lhrt_pkg::T_BRK && s_r.hdr_diag
    |-> s_r.st_left == 17'h0)
    else $error("request frame gap not kept");

  resp_wait_a : assert property (
    @(posedge clk) disable iff (reset)
    s_r.resp_go |-> $past(s_r.p2_left) == 17'h0 && !$past(s_r.master))
    else $error("response before request-to-response time");

  brk_low_a : assert property (
    @(posedge clk) disable iff (reset)
    $rose(s_r.tx_state == lhrt_pkg::T_BRK) |-> !s_r.lin_tx [*2])
    else $error("break not driven low");

endmodule : lhrt_core

//--- lhrt_lin_node.sv
// Remote LIN master node model: sends frame headers on the device's receive line.
// Assumes the bench clock and a bit period of BIT clock cycles; the line idles high.
module lhrt_lin_node #(
  parameter int BIT = 8
) (
  input wire logic clk,
  input wire logic start,
  input wire logic [5:0] id,
  output logic lin_rx,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    lin_rx = 1'b1;
    busy = 1'b0;
  end

  task automatic hold(input logic v, input int n);
    lin_rx <= v;
    repeat (n) @(posedge clk);
  endtask : hold

  task automatic frame(input logic [7:0] b);
    hold(1'b0, BIT);
    for (int i = 0; i < 8; i++) begin
      hold(b[i], BIT);
    end
    hold(1'b1, BIT);
  endtask : frame

  // ----------------------------------------
  // Header generation
  // ----------------------------------------
  // one header per request
  always begin
    @(posedge clk);
    if (start === 1'b1) begin
      busy <= 1'b1;
      hold(1'b0, 13 * BIT);
      hold(1'b1, BIT);
      frame(8'h55);
      // protected id that slaves match on
      frame({~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id});
      // The final stop bit leaves the line driven high
      busy <= 1'b0;
    end
  end
endmodule : lhrt_lin_node

//--- lhrt_pkg.sv
// Constants, types and helpers for the LIN header and role timing block.
// Assumes a single 25 MHz clock domain and a word-addressed Avalon-MM bus.

package lhrt_pkg;

  // ----------------------------------------
  // Clock and time
  // ----------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int MS_CYCLES_DEF = CLK_HZ / 1000;
  localparam real P2_DEF_S = 0.05;
  localparam real ST_DEF_S = 0.0;
  localparam logic [15:0] P2_RST = 16'(int'(P2_DEF_S * 1000.0));
  localparam logic [15:0] ST_RST = 16'(int'(ST_DEF_S * 1000.0));
  localparam int BAUD_DEF = 19200;
  localparam logic [15:0] DIV_RST = 16'(CLK_HZ / BAUD_DEF);
  localparam logic [15:0] DIV_9600 = 16'(CLK_HZ / 9600);

  // ----------------------------------------
  // Header timing
  // ----------------------------------------
  localparam logic [5:0] BRK_MIN = 6'h0a;
  localparam logic [5:0] BRK_MAX = 6'h24;
  localparam logic [5:0] BRK_LOW_MAX = 6'h0e;
  localparam logic [5:0] BRK_RST = 6'h0d;
  localparam logic [3:0] DLM_RST = 4'h0;
  localparam int BUILTIN_DIV = 9;
  localparam int SLV_BRK_MIN = 11;
  localparam logic [7:0] SYNC_BYTE = 8'h55;
  localparam logic [3:0] LAST_BIT = 4'h9;
  localparam logic [3:0] RX_LAST = 4'h7;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_BRK = 6'h04;
  localparam logic [5:0] OFS_DLM = 6'h08;
  localparam logic [5:0] OFS_P2 = 6'h0c;
  localparam logic [5:0] OFS_ST = 6'h10;
  localparam logic [5:0] OFS_SCHED = 6'h14;
  localparam logic [5:0] OFS_RESP = 6'h18;
  localparam logic [5:0] OFS_DIV = 6'h1c;
  localparam logic [5:0] OFS_STAT = 6'h20;
  localparam logic [5:0] OFS_CLR = 6'h24;
  localparam logic [5:0] OFS_IEN = 6'h28;
  localparam logic [5:0] OFS_STATE = 6'h2c;

  // Status bit positions
  localparam int SB_HDR = 0;
  localparam int SB_MATCH = 1;
  localparam int SB_ERR = 2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    T_IDLE = 4'h1, T_BRK = 4'h2, T_DLM = 4'h4, T_BYTE = 4'h8
  } lhrt_tx_t;

  typedef enum logic [4:0] {
    R_IDLE = 5'h01, R_BRK = 5'h02, R_WAIT = 5'h04,
    R_BYTE = 5'h08, R_STOP = 5'h10
  } lhrt_rx_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } lhrt_av_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } lhrt_av_rsp_t;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [3:0] dlm_max(input logic [5:0] b);
    case (b)
      6'h0a: dlm_max = 4'h8;
      6'h0b: dlm_max = 4'h7;
      6'h0c: dlm_max = 4'h6;
      6'h0d: dlm_max = 4'h5;
      6'h0e: dlm_max = 4'h4;
      6'h0f: dlm_max = 4'h2;
      6'h10: dlm_max = 4'h1;
      default: dlm_max = 4'h0;
    endcase
  endfunction : dlm_max

  // Slow links keep the break short so bus hold times are not violated
  function automatic logic [5:0] brk_lim(input logic [15:0] d);
    brk_lim = (d > DIV_9600) ? BRK_LOW_MAX : BRK_MAX;
  endfunction : brk_lim

  function automatic logic [7:0] pid(input logic [5:0] id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    pid = {p1, p0, id};
  endfunction : pid

endpackage : lhrt_pkg

//--- testbench.sv
// Self-checking bench for the LIN header and role timing core.
// Assumes one 25 MHz clock; a remote master model drives the receive line.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic reset = 1'b1;
  lhrt_pkg::lhrt_av_req_t av_req = '0;
  lhrt_pkg::lhrt_av_rsp_t av_rsp;
  logic lin_rx;
  logic lin_tx;
  logic resp_go;
  logic irq;
  logic diag_req_rx_done = 1'b0;
  logic diag_frame_tx_done = 1'b0;
  logic node_start = 1'b0;
  logic [5:0] node_id = 6'h00;
  logic node_busy;
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  int go_cnt = 0;
  int tx_lo = 0;
  int mx[8] = '{8, 7, 6, 5, 4, 2, 1, 0};

  always #20 clk = ~clk;

  // Short millisecond keeps diagnostic timers within a brief run
  lhrt_core #(.MS_CYCLES(25)) DUT (
    .clk(clk),
    .reset(reset),
    .av_req(av_req),
    .av_rsp(av_rsp),
    .lin_rx(lin_rx),
    .lin_tx(lin_tx),
    .diag_req_rx_done(diag_req_rx_done),
    .diag_frame_tx_done(diag_frame_tx_done),
    .resp_go(resp_go),
    .irq(irq)
  );

  lhrt_lin_node #(.BIT(8)) NODE (
    .clk(clk),
    .start(node_start),
    .id(node_id),
    .lin_rx(lin_rx),
    .busy(node_busy)
  );

  always @(posedge clk) begin
    cyc++;
    if (resp_go === 1'b1) go_cnt++;
    if (lin_tx === 1'b0) tx_lo++;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      mismatches++;
    end
  endtask : chk

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
    av_req <= '{read: ~w, write: w, address: a[5:2], writedata: d};
    @(posedge clk);
    // Only the bench timeout ends a wait for the answer
    while (av_rsp.waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    r = av_rsp.readdata;
    av_req <= '0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rc(input string nm, input logic [5:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    logic [31:0] r;
    bus(1'b0, a, '0, r);
    chk(nm, e, r & m);
  endtask : rc

  // A refused write flags the error bit; cleared again for the next case
  task automatic rej(input logic [5:0] a, input logic [31:0] d);
    wr(a, d);
    rc("refused", 6'h20, 32'h0000_0004, 32'h0000_0004);
    wr(6'h24, 32'h0000_0007);
  endtask : rej

  task automatic hdr_mon(output int lo, output int hi, output logic [15:0] by);
    int n;
    lo = 0;
    hi = 0;
    n = 0;
    while (lin_tx !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    while (lin_tx === 1'b0) begin
      @(posedge clk);
      lo++;
    end
    while (lin_tx === 1'b1) begin
      @(posedge clk);
      hi++;
    end
    for (int k = 0; k < 2; k++) begin
      while (k == 1 && lin_tx === 1'b1) @(posedge clk);
      repeat (4) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (8) @(posedge clk);
        by[8 * k + i] = lin_tx;
      end
      repeat (8) @(posedge clk);
      chk("stop_bit", 1'b1, lin_tx);
    end
  endtask : hdr_mon

  task automatic send_hdr(input logic [5:0] id);
    int n;
    n = 0;
    node_id <= id;
    node_start <= 1'b1;
    @(posedge clk);
    node_start <= 1'b0;
    @(posedge clk);
    while (node_busy === 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    repeat (20) @(posedge clk);
  endtask : send_hdr

  task automatic pulse(input logic f);
    if (f) diag_frame_tx_done <= 1'b1;
    else diag_req_rx_done <= 1'b1;
    @(posedge clk);
    diag_frame_tx_done <= 1'b0;
    diag_req_rx_done <= 1'b0;
    @(posedge clk);
  endtask : pulse

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int lo;
    int hi;
    int n;
    int g;
    logic [15:0] by;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rc("ctrl_rst", 6'h00, '0);
    rc("brk_rst", 6'h04, 32'h0000_000d);
    rc("dlm_rst", 6'h08, '0);
    rc("p2_rst", 6'h0c, 32'h0000_0032);
    rc("st_rst", 6'h10, '0);
    rc("div_rst", 6'h1c, 32'(lhrt_pkg::DIV_RST));
    rc("stat_rst", 6'h20, '0);
    rc("unmapped", 6'h3c, '0);
    rej(6'h1c, '0);
    wr(6'h1c, 32'h0000_0008);
    for (int b = 10; b < 18; b++) begin
      wr(6'h08, '0);
      wr(6'h04, 32'(b));
      rej(6'h08, 32'(mx[b - 10] + 1));
      wr(6'h08, 32'(mx[b - 10]));
      rc("dlm_max", 6'h08, 32'(mx[b - 10]));
    end
    wr(6'h08, '0);
    rej(6'h04, 32'h0000_0009);
    rej(6'h04, 32'h0000_0025);
    rej(6'h04, 32'h0000_004a);
    wr(6'h04, 32'h0000_0024);
    rc("brk_top", 6'h04, 32'h0000_0024);
    wr(6'h1c, 32'h0000_0a2d);
    rej(6'h04, 32'h0000_000f);
    wr(6'h04, 32'h0000_000e);
    rc("brk_slow", 6'h04, 32'h0000_000e);
    wr(6'h1c, 32'h0000_0008);
    wr(6'h08, 32'h0000_0004);
    rej(6'h04, 32'h0000_000f);
    wr(6'h08, 32'h0000_0002);
    wr(6'h04, 32'h0000_000a);
    wr(6'h0c, 32'h0000_0014);
    rc("p2_slave", 6'h0c, 32'h0000_0014);
    wr(6'h28, 32'h0000_0001);
    fork
      wr(6'h14, 32'h0000_0001);
      hdr_mon(lo, hi, by);
    join
    chk("break_len", 80, lo);
    chk("delim_len", 80 / 9 + 16, hi);
    chk("sync", 8'h55, by[7:0]);
    // Protected id of 0x01: both parity bits set
    chk("pid", 8'hc1, by[15:8]);
    repeat (10) @(posedge clk);
    chk("irq_hdr", 1'b1, irq);
    rc("role_sched", 6'h00, 32'h0000_0003, 32'h0000_0003);
    wr(6'h24, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irq_clr", 1'b0, irq);
    wr(6'h0c, 32'h0000_0005);
    repeat (2) @(posedge clk);
    chk("irq_mask", 1'b0, irq);
    rc("p2_err", 6'h20, 32'h0000_0004, 32'h0000_0004);
    rc("p2_kept", 6'h0c, 32'h0000_0014);
    wr(6'h28, 32'h0000_0005);
    repeat (2) @(posedge clk);
    chk("irq_err", 1'b1, irq);
    wr(6'h24, 32'h0000_0007);
    wr(6'h10, 32'h0000_0002);
    pulse(1'b1);
    n = 0;
    fork
      wr(6'h14, 32'h0000_0101);
      while (lin_tx !== 1'b0 && n < 1000) begin
        @(posedge clk);
        n++;
      end
    join
    chk("req_gap", 1'b1, n >= 45 && n <= 90);
    repeat (400) @(posedge clk);
    rej(6'h00, 32'h0000_0001);
    rc("keep_master", 6'h00, 32'h0000_0002, 32'h0000_0002);
    wr(6'h00, 32'h0000_0002);
    wr(6'h00, '0);
    rc("to_slave", 6'h00, '0, 32'h0000_0003);
    wr(6'h10, 32'h0000_0014);
    wr(6'h18, 32'h0000_0001);
    wr(6'h00, 32'h0000_0001);
    rej(6'h14, 32'h0000_0001);
    g = go_cnt;
    n = tx_lo;
    send_hdr(6'h02);
    chk("other_id", g, go_cnt);
    send_hdr(6'h01);
    chk("match", g + 1, go_cnt);
    rc("stat_match", 6'h20, 32'h0000_0002, 32'h0000_0002);
    for (int k = 0; k < 2; k++) begin
      g = go_cnt;
      pulse(k[0]);
      send_hdr(6'h01);
      chk("timer_hold", g, go_cnt);
      repeat (600) @(posedge clk);
      send_hdr(6'h01);
      chk("timer_done", g + 1, go_cnt);
    end
    chk("no_tx_slave", n, tx_lo);
    report_and_stop();
  end
endmodule : testbench
